// File: hdl/cms_sequencer.sv
// Core memory cycle sequencer: timing taps, address latch, decode, AXI4-Lite.
// Assumes processor pins are asynchronous to sys_clk and pulses last >= 2 clocks.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

// Functional notes
// - A processor clock pulse starts a cycle only while the request level is high.
// - Cycle-begin lasts 120 ns; address load pulse 50 ns wide at +150 ns.
// - Read drive sets near +220 ns, only when the bank matches.
// - Bank match needs both high address bits equal to the bank switches.
// - Switch codes 00,01,10,11 select the four 8K banks in order.
// - Read drive stays on about 420 ns for read current.
// - Sense strobes both halves at +560 ns; data-valid strobe at +600 ns.
// - Read drive ends at +635 ns; read-off at +660 ns launches write chain.
// - Both inhibit flops set together at +890 ns after the +825 ns tap.
// - Write drive sets at +920 ns.
// - Inhibit and write drive both end near +1330 ns.
// - Bit inhibit active when the buffer bit is 0 during write.
// - Abort clear drops read, inhibit and write at once.
// - A new cycle starts at the next processor clock pulse with request.
// - Address load captures the low 13 buffer bits.
// - Top address bit picks field 0 select or field 1 select.
// - X decode from bits 06-11, Y from 00-05, one of 64 lines each.
// - Sensed ones set the matching memory buffer bits for restore.
// - Fields of 4096 18-bit words, up to 32768 words.
module cms_sequencer #(
    parameter logic [7:0] READ_SET_CYC = cms_pkg::C_READ_SET,
    parameter logic [7:0] INH_SET_CYC = cms_pkg::C_INH_SET,
    parameter logic [7:0] WRITE_SET_CYC = cms_pkg::C_WRITE_SET,
    parameter logic [7:0] WRITE_OFF_CYC = cms_pkg::C_WRITE_OFF
) (
    // Clock and reset
    input logic sys_clk,
    input logic reset_n,
    // Processor side
    input logic cpClkPulse,
    input logic memoryCycleRequest,
    input logic consoleAbortClear,
    input logic extAddrHiBitA,
    input logic extAddrHiBitB,
    input logic [17:0] memoryBuffer,
    input logic [17:0] senseIn,
    // Stack drive
    output logic cycleBegin,
    output logic addressLoadPulse,
    output logic [12:0] addressLatch,
    output logic field0Select,
    output logic field1Select,
    output logic [63:0] xLine,
    output logic [63:0] yLine,
    output logic readDrive,
    output logic [1:0] senseSampleStrobe,
    output logic dataValidStrobe,
    output logic inhibitField0,
    output logic inhibitField1,
    output logic [17:0] inhibitBit,
    output logic writeDrive,
    output logic [17:0] bufferSetPulse,
    // AXI4-Lite slave
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready
);
    localparam int SYNC_W = 41;

    logic [1:0] rstSync_q;
    logic rstN;
    logic [SYNC_W-1:0] syncA_q, syncB_q;
    logic cpPrev_q, abortPrev_q;
    logic cpRise, abortRise, reqSync, extA, extB, bankHit;
    logic [17:0] mbSync, senseSync;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'h1};
        end
    end
    assign rstN = rstSync_q[1];

    // Pins pass two flops; edges are taken only from the second stage
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            syncA_q <= '0;
            syncB_q <= '0;
            cpPrev_q <= 1'h0;
            abortPrev_q <= 1'h0;
        end else begin
            syncA_q <= {cpClkPulse, memoryCycleRequest, consoleAbortClear, extAddrHiBitA,
                        extAddrHiBitB, memoryBuffer, senseIn};
            syncB_q <= syncA_q;
            cpPrev_q <= syncB_q[40];
            abortPrev_q <= syncB_q[38];
        end
    end
    assign cpRise = syncB_q[40] && !cpPrev_q;
    assign reqSync = syncB_q[39];
    assign abortRise = syncB_q[38] && !abortPrev_q;
    assign extA = syncB_q[37];
    assign extB = syncB_q[36];
    assign mbSync = syncB_q[35:18];
    assign senseSync = syncB_q[17:0];

    // Sequencer state
    cms_pkg::cms_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [1:0] bankSw_q, bankSw_d;
    logic match_q, match_d, chain_q, chain_d, tap_q, tap_d;
    logic readDrive_q, readDrive_d, inh_q, inh_d, inh1_q, writeDrive_q, writeDrive_d;
    logic cycleBegin_q, cycleBegin_d, load_q, load_d, data_q, data_d;
    logic [1:0] sense_q, sense_d;
    logic [12:0] latch_q, latch_d;
    logic [63:0] xLine_q, xLine_d, yLine_q, yLine_d;
    logic [17:0] inhBit_q, inhBit_d, bufSet_q, bufSet_d;
    logic [15:0] cycles_q, cycles_d;
    logic [1:0] fieldSel_q, fieldSel_d;
    logic run;

    // Match only when the bank's switch pair equals the high address pair
    assign bankHit = (extA == bankSw_q[1]) && (extB == bankSw_q[0]);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        match_d = match_q;
        chain_d = chain_q;
        tap_d = tap_q;
        readDrive_d = readDrive_q;
        inh_d = inh_q;
        writeDrive_d = writeDrive_q;
        latch_d = latch_q;
        cycles_d = cycles_q;
        case (state_q)
            cms_pkg::ST_IDLE: begin
                if (cpRise && reqSync) begin
                    state_d = cms_pkg::ST_RUN;
                    cnt_d = 8'h00;
                    match_d = 1'h0;
                    chain_d = 1'h0;
                    tap_d = 1'h0;
                end
            end
            cms_pkg::ST_RUN: begin
                cnt_d = cnt_q + 8'h01;
            end
            default: state_d = cms_pkg::ST_IDLE;
        endcase
        if (state_d == cms_pkg::ST_RUN) begin
            if (cnt_d == cms_pkg::C_LOAD_AT) begin
                latch_d = mbSync[12:0];
            end
            if (cnt_d == READ_SET_CYC) begin
                match_d = bankHit;
                readDrive_d = bankHit;
            end
            if (cnt_d == cms_pkg::C_READ_OFF) begin
                readDrive_d = 1'h0;
            end
            if (cnt_d == cms_pkg::C_READ_OFF_STATE) begin
                chain_d = match_q;
            end
            if (cnt_d == cms_pkg::C_INH_TAP) begin
                tap_d = chain_q;
            end
            if (cnt_d == INH_SET_CYC) begin
                inh_d = tap_q;
            end
            if (cnt_d == WRITE_SET_CYC) begin
                writeDrive_d = tap_q;
            end
            if (cnt_d == WRITE_OFF_CYC) begin
                inh_d = 1'h0;
                writeDrive_d = 1'h0;
                state_d = cms_pkg::ST_IDLE;
                cycles_d = cycles_q + 16'h0001;
            end
        end
        // Abort wins over the read, inhibit, write and chain taps in the same cycle
        if (abortRise) begin
            readDrive_d = 1'h0;
            inh_d = 1'h0;
            writeDrive_d = 1'h0;
            chain_d = 1'h0;
            tap_d = 1'h0;
            state_d = cms_pkg::ST_IDLE;
        end
        run = (state_d == cms_pkg::ST_RUN);
        cycleBegin_d = run && (cnt_d < cms_pkg::C_BEGIN_W);
        load_d = run && (cnt_d >= cms_pkg::C_LOAD_AT)
                 && (cnt_d < cms_pkg::C_LOAD_AT + cms_pkg::C_LOAD_W);
        sense_d = {2{run && match_d && (cnt_d >= cms_pkg::C_SENSE_AT)
                     && (cnt_d < cms_pkg::C_SENSE_AT + cms_pkg::C_SENSE_W)}};
        data_d = run && match_d && (cnt_d >= cms_pkg::C_DATA_AT)
                 && (cnt_d < cms_pkg::C_DATA_AT + cms_pkg::C_DATA_W);
        inhBit_d = inh_d ? ~mbSync : 18'h00000;
        bufSet_d = sense_d[0] ? senseSync : 18'h00000;
        // Registered so the field selects switch with the latch, not a gate later
        fieldSel_d = {latch_d[cms_pkg::FIELD_BIT], !latch_d[cms_pkg::FIELD_BIT]};
    end

    // One of 64 lines per axis from the latched address
    for (genvar i = 0; i < cms_pkg::LINES; i++) begin : g_decode
        assign xLine_d[i] = (latch_d[cms_pkg::X_MSB:cms_pkg::X_LSB] == 6'(i));
        assign yLine_d[i] = (latch_d[cms_pkg::Y_MSB:0] == 6'(i));
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= cms_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            match_q <= 1'h0;
            chain_q <= 1'h0;
            tap_q <= 1'h0;
            readDrive_q <= 1'h0;
            inh_q <= 1'h0;
            inh1_q <= 1'h0;
            writeDrive_q <= 1'h0;
            latch_q <= 13'h0000;
            cycles_q <= 16'h0000;
            cycleBegin_q <= 1'h0;
            load_q <= 1'h0;
            sense_q <= 2'h0;
            data_q <= 1'h0;
            xLine_q <= 64'h1;
            yLine_q <= 64'h1;
            inhBit_q <= 18'h00000;
            bufSet_q <= 18'h00000;
            fieldSel_q <= 2'h1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            match_q <= match_d;
            chain_q <= chain_d;
            tap_q <= tap_d;
            readDrive_q <= readDrive_d;
            inh_q <= inh_d;
            inh1_q <= inh_d;
            writeDrive_q <= writeDrive_d;
            latch_q <= latch_d;
            cycles_q <= cycles_d;
            cycleBegin_q <= cycleBegin_d;
            load_q <= load_d;
            sense_q <= sense_d;
            data_q <= data_d;
            xLine_q <= xLine_d;
            yLine_q <= yLine_d;
            inhBit_q <= inhBit_d;
            bufSet_q <= bufSet_d;
            fieldSel_q <= fieldSel_d;
        end
    end

    assign cycleBegin = cycleBegin_q;
    assign addressLoadPulse = load_q;
    assign addressLatch = latch_q;
    assign field0Select = fieldSel_q[0];
    assign field1Select = fieldSel_q[1];
    assign xLine = xLine_q;
    assign yLine = yLine_q;
    assign readDrive = readDrive_q;
    assign senseSampleStrobe = sense_q;
    assign dataValidStrobe = data_q;
    assign inhibitField0 = inh_q;
    assign inhibitField1 = inh1_q;
    assign inhibitBit = inhBit_q;
    assign writeDrive = writeDrive_q;
    assign bufferSetPulse = bufSet_q;

    // AXI4-Lite slave; address and data may arrive in either order
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        bankSw_d = bankSw_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && awready_q) begin
            awHeld_d = 1'h1;
            awAddr_d = {s_axi_awaddr[7:2], 2'h0};
        end
        if (s_axi_wvalid && wready_q) begin
            wHeld_d = 1'h1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (awHeld_q && wHeld_q && !bvalid_q) begin
            awHeld_d = 1'h0;
            wHeld_d = 1'h0;
            bvalid_d = 1'h1;
            bresp_d = (awAddr_q == cms_pkg::REG_CTRL) ? cms_pkg::RESP_OKAY
                                                       : cms_pkg::RESP_SLVERR;
            if (awAddr_q == cms_pkg::REG_CTRL && wStrb_q[0]) begin
                bankSw_d = wData_q[1:0];
            end
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'h1;
            rresp_d = cms_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                cms_pkg::REG_CTRL: rdata_d = {30'h0, bankSw_q};
                cms_pkg::REG_STATUS: rdata_d = {27'h0, match_q, writeDrive_q, inh_q,
                                                readDrive_q, state_q == cms_pkg::ST_RUN};
                cms_pkg::REG_ADDR: rdata_d = {19'h0, latch_q};
                cms_pkg::REG_COUNT: rdata_d = {16'h0, cycles_q};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = cms_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !awHeld_d && !bvalid_d;
        wready_d = !wHeld_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            awHeld_q <= 1'h0;
            wHeld_q <= 1'h0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'h0;
            bresp_q <= 2'h0;
            bankSw_q <= cms_pkg::CTRL_RESET;
            rvalid_q <= 1'h0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            awready_q <= 1'h0;
            wready_q <= 1'h0;
            arready_q <= 1'h0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            bankSw_q <= bankSw_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstN);

    a_start_req: assert property ($rose(cycleBegin_q) |-> $past(reqSync, 1))
        else $error("cycle began without request");
    a_begin_width: assert property ($rose(cycleBegin_q) |-> cycleBegin_q [*8] ##1
        (cycleBegin_q || state_q == cms_pkg::ST_IDLE))
        else $error("cycle begin too short");
    a_load_offset: assert property ($rose(cycleBegin_q) |->
        ##15 (load_q || state_q == cms_pkg::ST_IDLE))
        else $error("address load not at offset");
    a_read_match: assert property ($rose(readDrive_q) |-> match_q && cnt_q == READ_SET_CYC)
        else $error("read drive without match or off time");
    a_read_end: assert property ($fell(readDrive_q) |->
        cnt_q == cms_pkg::C_READ_OFF || state_q == cms_pkg::ST_IDLE)
        else $error("read drive ended at wrong time");
    a_sense_data: assert property ($rose(data_q) |-> $past(sense_q[0], 4) && sense_q[1])
        else $error("data strobe not after sense strobe");
    a_inhibit_pair: assert property (inh_q == inh1_q)
        else $error("inhibit flops differ");
    a_write_after: assert property ($rose(writeDrive_q) |->
        $past(inh_q, 3) && !$past(inh_q, 4))
        else $error("write drive not 3 cycles after inhibit");
    a_write_off: assert property ($fell(writeDrive_q) |-> !inh_q && !inh1_q)
        else $error("inhibit outlived write drive");
    a_inhibit_bits: assert property (inhBit_q != 18'h00000 |-> inh_q)
        else $error("bit inhibit outside write half");
    a_abort_clear: assert property (abortRise |=> !readDrive_q && !writeDrive_q && !inh_q)
        else $error("abort did not clear drive");
endmodule : cms_sequencer

// File: hdl/cms_pkg.sv
// Constants for the core memory cycle sequencer: tap times, cycle counts,
// register map and field layout.
// Assumes a 100 MHz system clock; every tap counts from cycle begin.
package cms_pkg;
    // Clock
    localparam int CLK_PERIOD_PS = 10000;

    // Tap times as nominal figures
    localparam int T_BEGIN_WIDTH_PS = 120000;
    localparam int T_LOAD_AT_PS = 150000;
    localparam int T_LOAD_WIDTH_PS = 50000;
    localparam int T_READ_ON_DELAY_PS = 37500;
    localparam int T_READ_SET_MIN_PS = 211500;
    localparam int T_READ_SET_MAX_PS = 220000;
    localparam int T_SENSE_AT_PS = 560000;
    localparam int T_SENSE_WIDTH_PS = 60000;
    localparam int T_DATA_STROBE_AT_PS = 600000;
    localparam int T_DATA_STROBE_WIDTH_PS = 50000;
    localparam int T_READ_OFF_PS = 635000;
    localparam int T_READ_OFF_STATE_PS = 660000;
    localparam int T_INH_TAP_PS = 825000;
    localparam int T_INH_SET_PS = 890000;
    localparam int T_WRITE_SET_PS = 920000;
    localparam int T_WRITE_OFF_PS = 1330000;

    // Cycle counts; least times round up
    localparam logic [7:0] C_BEGIN_W = 8'((T_BEGIN_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_LOAD_AT = 8'((T_LOAD_AT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_LOAD_W = 8'((T_LOAD_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_READ_SET = 8'((T_READ_SET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_SENSE_AT = 8'((T_SENSE_AT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_SENSE_W = 8'((T_SENSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_DATA_AT = 8'((T_DATA_STROBE_AT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_DATA_W = 8'((T_DATA_STROBE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_READ_OFF = 8'((T_READ_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_READ_OFF_STATE = 8'((T_READ_OFF_STATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_INH_TAP = 8'((T_INH_TAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_INH_SET = 8'((T_INH_SET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_WRITE_SET = 8'((T_WRITE_SET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] C_WRITE_OFF = 8'((T_WRITE_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Storage geometry
    localparam int WORD_W = 18;
    localparam int ADDR_W = 13;
    localparam int WORDS_PER_FIELD = 4096;
    localparam int MAX_WORDS = 32768;
    localparam int FIELD_BIT = 12;
    localparam int X_MSB = 11;
    localparam int X_LSB = 6;
    localparam int Y_MSB = 5;
    localparam int LINES = 64;

    // Register map, byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN = 2'h2
    } cms_state_t;
endpackage : cms_pkg

// File: verification/cms_cpu_model.sv
// Processor-side model: clock pulses, request level, abort pulse, buffer word.
// Assumes the bench raises go or abortGo for one clock, set at a rising edge.
`timescale 1ns/1ns
module cms_cpu_model (
    // Clock and bench commands
    input logic sys_clk,
    input logic go,
    input logic abortGo,
    input logic reqOn,
    input logic [17:0] mbIn,
    // Device feedback
    input logic cycleBegin,
    // Processor pins
    output logic cpClkPulse,
    output logic memoryCycleRequest,
    output logic consoleAbortClear,
    output logic [17:0] memoryBuffer
);
    logic [1:0] clkCnt_q = 2'h0;
    logic [1:0] abCnt_q = 2'h0;
    logic [7:0] busyCnt_q = 8'h0;
    initial memoryBuffer = 18'h0;
    // Three clocks wide, past the two-clock minimum of the pin synchroniser
    assign cpClkPulse = clkCnt_q != 2'h0;
    assign consoleAbortClear = abCnt_q != 2'h0;
    assign memoryCycleRequest = reqOn;
    always @(posedge sys_clk) begin
        if (go) clkCnt_q <= 2'h3;
        else if (clkCnt_q != 2'h0) clkCnt_q <= clkCnt_q - 2'h1;
        if (abortGo) abCnt_q <= 2'h3;
        else if (abCnt_q != 2'h0) abCnt_q <= abCnt_q - 2'h1;
        // Buffer frozen from cycle begin until past write end
        if (cycleBegin && busyCnt_q == 8'h0) busyCnt_q <= 8'h88;
        else if (busyCnt_q != 8'h0) busyCnt_q <= busyCnt_q - 8'h1;
        if (busyCnt_q == 8'h0 && !cycleBegin) memoryBuffer <= mbIn;
    end
endmodule : cms_cpu_model

// File: verification/tb.sv
// Self-checking bench for the core memory cycle sequencer.
// Assumes the processor model on the far side and AXI4-Lite driven here.
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [1:0] sw;
        logic [1:0] ext;
        logic [17:0] mb;
        logic [17:0] sn;
        logic [7:0] ab;
    } cms_row_t;
    logic sys_clk = 1'b0, reset_n = 1'b0, go = 1'b0, abortGo = 1'b0, reqOn = 1'b1;
    logic extAddrHiBitA = 1'b0, extAddrHiBitB = 1'b0;
    logic [17:0] mbIn = 18'h0, senseIn = 18'h0, memoryBuffer, inhibitBit, bufferSetPulse;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, senseSampleStrobe;
    logic cpClkPulse, memoryCycleRequest, consoleAbortClear, cycleBegin, addressLoadPulse;
    logic field0Select, field1Select, readDrive, dataValidStrobe;
    logic inhibitField0, inhibitField1, writeDrive;
    logic [12:0] addressLatch;
    logic [63:0] xLine, yLine;
    int nErrors = 0;
    int samplesChecked = 0;
    // Four matched banks first, then two mismatches, then an abort mid-write
    cms_row_t rows[7] = '{
        '{2'h0, 2'h0, 18'h0a5c3, 18'h2a5a5, 8'h0}, '{2'h1, 2'h1, 18'h31fff, 18'h15a5a, 8'h0},
        '{2'h2, 2'h2, 18'h00000, 18'h3ffff, 8'h0}, '{2'h3, 2'h3, 18'h3ffff, 18'h00001, 8'h0},
        '{2'h2, 2'h1, 18'h1c0ff, 18'h3ffff, 8'h0}, '{2'h1, 2'h3, 18'h02040, 18'h3ffff, 8'h0},
        '{2'h3, 2'h3, 18'h12345, 18'h0f0f0, 8'h64}};

    cms_cpu_model cpu (.sys_clk, .go, .abortGo, .reqOn, .mbIn, .cycleBegin, .cpClkPulse,
        .memoryCycleRequest, .consoleAbortClear, .memoryBuffer);
    cms_sequencer dut (.sys_clk, .reset_n, .cpClkPulse, .memoryCycleRequest,
        .consoleAbortClear, .extAddrHiBitA, .extAddrHiBitB, .memoryBuffer, .senseIn,
        .cycleBegin, .addressLoadPulse, .addressLatch, .field0Select, .field1Select, .xLine,
        .yLine, .readDrive, .senseSampleStrobe, .dataValidStrobe, .inhibitField0,
        .inhibitField1, .inhibitBit, .writeDrive, .bufferSetPulse, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Handshake flags are sampled settled, just before the edge that takes them
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, bt;
        logic [1:0] rsp;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bt = 1'b0;
        while (!bt) begin
            #1;
            ah = s_axi_awready;
            wh = s_axi_wready;
            bt = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge sys_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(rsp, er);
    endtask : axiWr

    task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ah, rt;
        logic [33:0] got;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rt = 1'b0;
        while (!rt) begin
            #1;
            ah = s_axi_arready;
            rt = s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge sys_clk);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(got, {er, ed});
    endtask : axiRd

    task automatic runCycle(input cms_row_t r);
        logic m, ab;
        logic [8:0] e;
        int w;
        m = r.sw == r.ext;
        axiWr(cms_pkg::REG_CTRL, {30'h0, r.sw}, cms_pkg::RESP_OKAY);
        @(posedge sys_clk);
        extAddrHiBitA <= r.ext[1];
        extAddrHiBitB <= r.ext[0];
        mbIn <= r.mb;
        senseIn <= r.sn;
        reqOn <= 1'b1;
        go <= 1'b1;
        w = 0;
        do begin
            @(posedge sys_clk);
            go <= 1'b0;
            #1;
            w++;
        end while (!cycleBegin && w < 20);
        chk(cycleBegin, 1'b1);
        for (int n = 1; n <= 140; n++) begin
            @(posedge sys_clk);
            go <= n == 40;
            abortGo <= n == r.ab;
            #1;
            ab = r.ab != 8'h0 && n >= r.ab;
            e = {n < 12, n >= 15 && n < 20, n >= 22 && n < 64, {2{n >= 56 && n < 62}},
                n >= 60 && n < 65, {2{n >= 89 && n < 133}}, n >= 92 && n < 133};
            e[6:0] = e[6:0] & {7{m && !ab}};
            if (!ab || n >= r.ab + 8) chk({cycleBegin, addressLoadPulse, readDrive,
                senseSampleStrobe, dataValidStrobe, inhibitField0, inhibitField1,
                writeDrive}, e);
            if (n == 20) begin
                chk(addressLatch, r.mb[12:0]);
                chk({field1Select, field0Select}, {r.mb[12], !r.mb[12]});
                chk({xLine, yLine}, {64'h1 << r.mb[11:6], 64'h1 << r.mb[5:0]});
            end
            if (n == 58) chk(bufferSetPulse, m ? r.sn : 18'h0);
            if (n == 95) chk(inhibitBit, m ? 18'(~r.mb) : 18'h0);
        end
    endtask : runCycle

    task automatic summarize();
        $display("errors %0d checks %0d", nErrors, samplesChecked);
        if (nErrors == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        #60000;
        nErrors++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        chk({xLine, yLine}, {64'h1, 64'h1});
        chk({field0Select, field1Select, readDrive, writeDrive}, 4'h8);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        axiRd(cms_pkg::REG_CTRL, 32'h0, cms_pkg::RESP_OKAY);
        foreach (rows[i]) begin
            runCycle(rows[i]);
            if (i == 3) axiRd(cms_pkg::REG_COUNT, 32'h4, cms_pkg::RESP_OKAY);
        end
        axiRd(cms_pkg::REG_ADDR, {19'h0, rows[6].mb[12:0]}, cms_pkg::RESP_OKAY);
        axiRd(cms_pkg::REG_STATUS, 32'h10, cms_pkg::RESP_OKAY);
        axiWr(8'h10, 32'h0, cms_pkg::RESP_SLVERR);
        axiWr(cms_pkg::REG_STATUS, 32'h1f, cms_pkg::RESP_SLVERR);
        axiRd(8'h14, 32'h0, cms_pkg::RESP_SLVERR);
        axiRd(cms_pkg::REG_CTRL, 32'h3, cms_pkg::RESP_OKAY);
        // A clock pulse without the request level must not start anything
        @(posedge sys_clk);
        reqOn <= 1'b0;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            chk(cycleBegin, 1'b0);
        end
        runCycle(rows[0]);
        summarize();
    end
endmodule : tb
